// ==== include/csf_pkg.sv ====
// Package with register map, field positions, reset values and mode encodings
package csf_pkg;
  // Register byte offsets
  localparam logic [7:0] CSF_OFF_MAIN_CONTROL = 8'h00;
  localparam logic [7:0] CSF_OFF_MAIN_STATUS = 8'h04;
  localparam logic [7:0] CSF_OFF_TRANSMIT_STATUS = 8'h08;
  localparam logic [7:0] CSF_OFF_EVENT_CONTROL = 8'h0C;
  // Reset values
  localparam logic [31:0] CSF_RST_MAIN_CONTROL = 32'h0000_0002;
  localparam logic [31:0] CSF_RST_MAIN_STATUS = 32'h0000_0C02;
  localparam logic [31:0] CSF_RST_TRANSMIT_STATUS = 32'h1C00_0000;
  // Main control fields
  localparam int CSF_BIT_INIT_REQUEST = 0;
  localparam int CSF_BIT_SLEEP_REQUEST = 1;
  localparam int CSF_BIT_AUTO_WAKE_SELECT = 5;
  // Main status fields
  localparam int CSF_BIT_INIT_ACK = 0;
  localparam int CSF_BIT_SLEEP_ACK = 1;
  localparam int CSF_BIT_ERROR_IRQ = 2;
  localparam int CSF_BIT_WAKE_IRQ = 3;
  localparam int CSF_BIT_SLEEP_ENTRY_IRQ = 4;
  localparam int CSF_BIT_TX_ACTIVE = 8;
  localparam int CSF_BIT_RX_ACTIVE = 9;
  localparam int CSF_BIT_RX_LAST_SAMPLE = 10;
  localparam int CSF_BIT_RX_PIN_LEVEL = 11;
  // Transmit status fields for mailbox 0
  localparam int CSF_BIT_MB0_REQUEST_DONE = 0;
  localparam int CSF_BIT_MB0_TX_OK = 1;
  localparam int CSF_BIT_MB0_ARB_LOST = 2;
  localparam int CSF_BIT_MB0_TX_FAIL = 3;
  // Event control register: software stand-in for a mailbox 0 transmit request
  localparam int CSF_BIT_MB0_TX_REQUEST = 0;
  // Read data of an unmapped address
  localparam logic [31:0] CSF_UNMAPPED_DATA = 32'h0000_0000;
  // Operating modes
  typedef enum logic [1:0] {
    CSF_MODE_SLEEP = 2'b00,
    CSF_MODE_INIT = 2'b01,
    CSF_MODE_NORMAL = 2'b10
  } csf_mode_t;
endpackage : csf_pkg

// ==== hdl/csf_w1c_flag.sv ====
// Sticky status flag: hardware set, write-one clear, optional hardware clear
`timescale 1ns/1ps
`default_nettype none
module csf_w1c_flag (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_set,
  input wire logic i_sw_clear,
  input wire logic i_hw_clear,
  output logic o_flag
);
  // Next value: set beats any clear so an event is never lost
  logic next_flag;
  assign next_flag = i_set | (o_flag & ~i_sw_clear & ~i_hw_clear);

  // Flag storage
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_flag <= 1'b0;
    end else if (i_ce) begin
      o_flag <= next_flag;
    end
  end
endmodule : csf_w1c_flag
`default_nettype wire

// ==== hdl/csf_status_flags.sv ====
// CAN status flag block with main status and mailbox 0 transmit status words
// Function
// - Init ack set only in initialization mode
// - Sleep ack high while in sleep mode
// - Error flag sticky, write one clears
// - Wake flag on start-of-frame during sleep
// - Sleep-entry flag set on entry, cleared leaving
// - Bit 8 shows transmission in progress
// - Bit 9 shows reception in progress
// - Bit 10 shows receive pin last sample
// - Bit 11 shows current receive pin level
// - Mailbox 0 request done on completion
// - New transmit request clears request done
// - Mailbox 0 success flag, write one clears
// - Mailbox 0 arbitration lost, write one clears
// - Mailbox 0 error flag, write one clears
// - Main status at 0x04, reset 0x00000C02
// - Transmit status at 0x08, reset 0x1C000000
// - Auto wake clears sleep request on activity
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module csf_status_flags (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Classic Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Events from the bit-stream engine
  input wire logic i_rx_pin,
  input wire logic i_sample_point,
  input wire logic i_tx_active,
  input wire logic i_rx_active,
  input wire logic i_error_event,
  input wire logic i_sof_detect,
  input wire logic i_mb0_done,
  input wire logic i_mb0_ok,
  input wire logic i_mb0_arb_lost,
  input wire logic i_mb0_fail,
  // Mode and transmit start outputs towards the engine
  output logic o_init_ack,
  output logic o_sleep_ack,
  output logic o_sleep_irq,
  output logic o_mb0_tx_start
);
  import csf_pkg::*;

  // Control and state registers
  logic init_request;                 // Software init request
  logic sleep_request;                // Software sleep request
  logic auto_wake_select;             // Hardware wake enable
  csf_mode_t mode;                    // Current operating mode
  logic rx_last_sample;               // Receive pin at last sample point
  logic rx_pin_level;                 // Receive pin registered level
  logic tx_active_flag;               // Transmitter busy
  logic rx_active_flag;               // Receiver busy
  logic mb0_request_done;             // Mailbox 0 request complete
  logic [31:0] next_rdata;            // Read mux result
  csf_mode_t next_mode;               // Mode transition result

  // Sticky flags built from the shared flag cell
  logic error_irq_flag;
  logic wake_irq_flag;
  logic sleep_entry_irq_flag;
  logic mb0_tx_ok;
  logic mb0_arb_lost;
  logic mb0_tx_fail;

  // Bus decode: request taken on the first cycle, ack the next
  wire bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire bus_wr = bus_req & i_wb_we & i_wb_sel[0];
  wire sel_ctrl = (i_wb_adr == CSF_OFF_MAIN_CONTROL);
  wire sel_msts = (i_wb_adr == CSF_OFF_MAIN_STATUS);
  wire sel_txsts = (i_wb_adr == CSF_OFF_TRANSMIT_STATUS);
  wire sel_evctl = (i_wb_adr == CSF_OFF_EVENT_CONTROL);
  wire wr_ctrl = bus_wr & sel_ctrl;
  wire wr_msts = bus_wr & sel_msts;
  wire wr_txsts = bus_wr & sel_txsts;
  wire wr_evctl = bus_wr & sel_evctl;

  // Write-one-clear strobes, reserved bits ignored
  wire clr_err = wr_msts & i_wb_dat[CSF_BIT_ERROR_IRQ];
  wire clr_wake = wr_msts & i_wb_dat[CSF_BIT_WAKE_IRQ];
  wire clr_slp = wr_msts & i_wb_dat[CSF_BIT_SLEEP_ENTRY_IRQ];
  wire clr_done = wr_txsts & i_wb_dat[CSF_BIT_MB0_REQUEST_DONE];
  wire clr_ok = wr_txsts & i_wb_dat[CSF_BIT_MB0_TX_OK];
  wire clr_arb = wr_txsts & i_wb_dat[CSF_BIT_MB0_ARB_LOST];
  wire clr_fail = wr_txsts & i_wb_dat[CSF_BIT_MB0_TX_FAIL];

  // Accepted mailbox 0 transmit request
  wire tx_req = wr_evctl & i_wb_dat[CSF_BIT_MB0_TX_REQUEST];

  // Mode events
  wire in_sleep = (mode == CSF_MODE_SLEEP);
  wire wake_seen = in_sleep & i_sof_detect;
  wire auto_wake = wake_seen & auto_wake_select;
  wire enter_sleep = (next_mode == CSF_MODE_SLEEP) & ~in_sleep;
  wire leave_sleep = in_sleep & (next_mode != CSF_MODE_SLEEP);

  // Mode transitions from the request bits
  always_comb begin
    case (mode)
      CSF_MODE_SLEEP: begin
        if (init_request) begin
          next_mode = CSF_MODE_INIT;
        end else if (!sleep_request || auto_wake) begin
          next_mode = CSF_MODE_NORMAL;
        end else begin
          next_mode = CSF_MODE_SLEEP;
        end
      end
      CSF_MODE_INIT: begin
        if (!init_request && sleep_request) begin
          next_mode = CSF_MODE_SLEEP;
        end else if (!init_request) begin
          next_mode = CSF_MODE_NORMAL;
        end else begin
          next_mode = CSF_MODE_INIT;
        end
      end
      CSF_MODE_NORMAL: begin
        if (init_request) begin
          next_mode = CSF_MODE_INIT;
        end else if (sleep_request) begin
          next_mode = CSF_MODE_SLEEP;
        end else begin
          next_mode = CSF_MODE_NORMAL;
        end
      end
      default: begin
        next_mode = CSF_MODE_SLEEP;
      end
    endcase
  end

  // Main status word assembly, reserved bits zero
  wire [31:0] main_status = {20'h00000,
    rx_pin_level,
    rx_last_sample,
    rx_active_flag,
    tx_active_flag,
    3'h0,
    sleep_entry_irq_flag,
    wake_irq_flag,
    error_irq_flag,
    o_sleep_ack,
    o_init_ack};

  // Transmit status word: mailboxes empty bits fixed at their reset value
  wire [31:0] transmit_status = (CSF_RST_TRANSMIT_STATUS & 32'hFFFF_FFF0) |
    {28'h0000000, mb0_tx_fail, mb0_arb_lost, mb0_tx_ok, mb0_request_done};

  // Main control word readback
  wire [31:0] main_control = {26'h0000000, auto_wake_select, 3'h0,
    sleep_request, init_request};

  // Read mux
  always_comb begin
    if (sel_ctrl) begin
      next_rdata = main_control;
    end else if (sel_msts) begin
      next_rdata = main_status;
    end else if (sel_txsts) begin
      next_rdata = transmit_status;
    end else begin
      next_rdata = CSF_UNMAPPED_DATA;
    end
  end

  // Bus answer: one-cycle ack and registered read data
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else if (i_ce) begin
      o_wb_ack <= bus_req;
      o_wb_dat <= bus_req ? next_rdata : 32'h0000_0000;
    end
  end

  // Control register and mode state
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      init_request <= CSF_RST_MAIN_CONTROL[CSF_BIT_INIT_REQUEST];
      sleep_request <= CSF_RST_MAIN_CONTROL[CSF_BIT_SLEEP_REQUEST];
      auto_wake_select <= CSF_RST_MAIN_CONTROL[CSF_BIT_AUTO_WAKE_SELECT];
      mode <= CSF_MODE_SLEEP;
    end else if (i_ce) begin
      mode <= next_mode;
      if (wr_ctrl) begin
        init_request <= i_wb_dat[CSF_BIT_INIT_REQUEST];
        auto_wake_select <= i_wb_dat[CSF_BIT_AUTO_WAKE_SELECT];
      end
      // Hardware clear on auto wake wins over a software write
      if (auto_wake) begin
        sleep_request <= 1'b0;
      end else if (wr_ctrl) begin
        sleep_request <= i_wb_dat[CSF_BIT_SLEEP_REQUEST];
      end
    end
  end

  // Mode acknowledges and receive pin status, all registered
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_init_ack <= CSF_RST_MAIN_STATUS[CSF_BIT_INIT_ACK];
      o_sleep_ack <= CSF_RST_MAIN_STATUS[CSF_BIT_SLEEP_ACK];
      rx_last_sample <= CSF_RST_MAIN_STATUS[CSF_BIT_RX_LAST_SAMPLE];
      rx_pin_level <= CSF_RST_MAIN_STATUS[CSF_BIT_RX_PIN_LEVEL];
      tx_active_flag <= 1'b0;
      rx_active_flag <= 1'b0;
      o_mb0_tx_start <= 1'b0;
    end else if (i_ce) begin
      o_init_ack <= (next_mode == CSF_MODE_INIT);
      o_sleep_ack <= (next_mode == CSF_MODE_SLEEP);
      rx_pin_level <= i_rx_pin;
      if (i_sample_point) begin
        rx_last_sample <= i_rx_pin;
      end
      tx_active_flag <= i_tx_active;
      rx_active_flag <= i_rx_active;
      o_mb0_tx_start <= tx_req;
    end
  end

  // Request-complete flag: set on done, cleared by new request or write one
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      mb0_request_done <= CSF_RST_TRANSMIT_STATUS[CSF_BIT_MB0_REQUEST_DONE];
    end else if (i_ce) begin
      if (i_mb0_done) begin
        mb0_request_done <= 1'b1;
      end else if (tx_req || clr_done) begin
        mb0_request_done <= 1'b0;
      end
    end
  end

  // Sleep interrupt output mirrors the sleep-entry flag
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_sleep_irq <= 1'b0;
    end else if (i_ce) begin
      o_sleep_irq <= enter_sleep | (sleep_entry_irq_flag & ~clr_slp & ~leave_sleep);
    end
  end

  // Error interrupt flag
  csf_w1c_flag u_err (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_set(i_error_event), .i_sw_clear(clr_err), .i_hw_clear(1'b0),
    .o_flag(error_irq_flag));
  // Wake-up interrupt flag
  csf_w1c_flag u_wake (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_set(wake_seen), .i_sw_clear(clr_wake), .i_hw_clear(1'b0),
    .o_flag(wake_irq_flag));
  // Sleep-entry flag with hardware clear on leaving sleep
  csf_w1c_flag u_slp (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_set(enter_sleep), .i_sw_clear(clr_slp), .i_hw_clear(leave_sleep),
    .o_flag(sleep_entry_irq_flag));
  // Mailbox 0 success flag
  csf_w1c_flag u_ok (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_set(i_mb0_ok), .i_sw_clear(clr_ok), .i_hw_clear(1'b0),
    .o_flag(mb0_tx_ok));
  // Mailbox 0 arbitration-lost flag
  csf_w1c_flag u_arb (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_set(i_mb0_arb_lost), .i_sw_clear(clr_arb), .i_hw_clear(1'b0),
    .o_flag(mb0_arb_lost));
  // Mailbox 0 transmit-error flag
  csf_w1c_flag u_fail (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_set(i_mb0_fail), .i_sw_clear(clr_fail), .i_hw_clear(1'b0),
    .o_flag(mb0_tx_fail));
endmodule : csf_status_flags
`default_nettype wire

// ==== verification/csf_can_model.sv ====
// Behavioural CAN bus side that launches engine event pulses
`timescale 1ns/1ps
`default_nettype none
module csf_can_model (
  input wire logic i_clk_sys,
  input wire logic [6:0] i_req,
  output logic [6:0] o_pulse
);
  // Each requested event leaves as a one-cycle pulse after the next edge
  always_ff @(posedge i_clk_sys) begin
    o_pulse <= i_req;
  end
endmodule : csf_can_model
`default_nettype wire

// ==== verification/csf_status_flags_properties.sv ====
// Port-level checker for the CAN status flag block
`timescale 1ns/1ps
`default_nettype none
module csf_status_flags_properties
  import csf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_init_ack,
  input wire logic o_sleep_ack,
  input wire logic o_sleep_irq,
  input wire logic o_mb0_tx_start
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // Bus answers one cycle after it takes a request
  property p_ack_next;
    i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_cause;
    o_wb_ack |-> $past(i_wb_cyc && i_wb_stb) ##1 !o_wb_ack;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle;
    !o_wb_ack |-> o_wb_dat == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_reset_out;
    $rose(i_rstn) |-> o_sleep_ack && !o_init_ack && !o_sleep_irq && !o_mb0_tx_start;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("bad reset outputs");
  property p_mode_excl;
    !(o_init_ack && o_sleep_ack);
  endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("two modes at once");
  property p_init_cause;
    $rose(o_init_ack) |-> $past(i_wb_we && i_wb_adr == CSF_OFF_MAIN_CONTROL);
  endproperty
  a_init_cause: assert property (p_init_cause) else $error("init ack uncaused");
  property p_sleep_irq;
    $rose(o_sleep_irq) |-> o_sleep_ack;
  endproperty
  a_sleep_irq: assert property (p_sleep_irq) else $error("sleep irq awake");
  property p_sleep_irq_clear;
    $fell(o_sleep_ack) |-> !o_sleep_irq;
  endproperty
  a_sleep_irq_clear: assert property (p_sleep_irq_clear) else $error("sleep irq kept");
  property p_tx_start;
    o_mb0_tx_start |-> $past(i_wb_we && i_wb_adr == CSF_OFF_EVENT_CONTROL) ##1 !o_mb0_tx_start;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("bad tx start");
  property p_main_res;
    o_wb_ack && $past(i_wb_adr) == CSF_OFF_MAIN_STATUS |->
      o_wb_dat[31:12] == 20'h0 && o_wb_dat[7:5] == 3'h0;
  endproperty
  a_main_res: assert property (p_main_res) else $error("main reserved set");
  property p_tx_res;
    o_wb_ack && $past(i_wb_adr) == CSF_OFF_TRANSMIT_STATUS |-> o_wb_dat[31:4] == 28'h1C0_0000;
  endproperty
  a_tx_res: assert property (p_tx_res) else $error("tx reserved bad");
  property p_unmapped;
    o_wb_ack && $past(i_wb_adr[7:4]) != 4'h0 |-> o_wb_dat == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
endmodule : csf_status_flags_properties
bind csf_status_flags csf_status_flags_properties csf_status_flags_properties_i (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .o_init_ack(o_init_ack), .o_sleep_ack(o_sleep_ack),
  .o_sleep_irq(o_sleep_irq), .o_mb0_tx_start(o_mb0_tx_start));
`default_nettype wire

// ==== verification/csf_status_flags_tb.sv ====
// Self-checking bench for the CAN status flag block
`timescale 1ns/1ps
`default_nettype none
module csf_status_flags_tb;
  import csf_pkg::*;
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, rxp = 1, txa = 0, rxa = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, e, rs = 32'h0001_0BA9;
  // Clock enable and the mode and start pins of the design
  logic ce = 1'b1, ina, sla, sli, txs;
  // Transmit start pulses seen on the pin
  int n_start = 0;
  logic ack;
  logic [6:0] req = 7'h00, pl;
  logic [31:0] exp_q[$];
  int failures = 0, n_tests = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  csf_can_model csf_can_model_i (.i_clk_sys(clk), .i_req(req), .o_pulse(pl));
  csf_status_flags csf_status_flags_i (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_rx_pin(rxp),
    .i_sample_point(pl[6]), .i_tx_active(txa), .i_rx_active(rxa),
    .i_error_event(pl[0]), .i_sof_detect(pl[1]), .i_mb0_done(pl[2]), .i_mb0_ok(pl[3]),
    .i_mb0_arb_lost(pl[4]), .i_mb0_fail(pl[5]), .o_init_ack(ina), .o_sleep_ack(sla),
    .o_sleep_irq(sli), .o_mb0_tx_start(txs));
  // Compares every answered read with the oldest noted expectation
  always @(posedge clk) begin
    if (txs === 1'b1) n_start++;
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      n_tests++;
      if (rdat !== e) begin
        failures++;
        $display("ERROR t=%0t got=%h exp=%h", $time, rdat, e);
      end
      // Mode and sleep interrupt pins must agree with the main status word
      if (adr === CSF_OFF_MAIN_STATUS && {sli, sla, ina} !== {e[4], e[1], e[0]}) begin
        failures++;
        $display("ERROR t=%0t pins=%h exp=%h", $time, {sli, sla, ina}, {e[4], e[1], e[0]});
      end
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // One classic Wishbone cycle; a read notes its expected word first
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    if (!w) exp_q.push_back(d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    @(posedge clk);
    // Wait for the answer as long as it takes; only the watchdog ends a hang
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 4'hF);
  endtask : rd
  // Asks the bus model for event pulses and lets the flags settle
  task automatic ev(input logic [6:0] r);
    req <= r;
    @(posedge clk);
    req <= 7'h00;
    repeat (2) @(posedge clk);
  endtask : ev
  task automatic test_done;
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(CSF_OFF_MAIN_STATUS, CSF_RST_MAIN_STATUS);
    rd(CSF_OFF_TRANSMIT_STATUS, CSF_RST_TRANSMIT_STATUS);
    wr(CSF_OFF_MAIN_CONTROL, 32'h0000_0022);
    ev(7'h02);
    rd(CSF_OFF_MAIN_STATUS, 32'h0000_0C08);
    rd(CSF_OFF_MAIN_CONTROL, 32'h0000_0020);
    wr(CSF_OFF_MAIN_STATUS, 32'h0000_0008);
    ev(7'h01);
    wr(CSF_OFF_MAIN_STATUS, 32'hFFFF_FFFB);
    bus(1'b1, CSF_OFF_MAIN_STATUS, 32'h0000_0004, 4'hE);
    rd(CSF_OFF_MAIN_STATUS, 32'h0000_0C04);
    wr(CSF_OFF_MAIN_STATUS, 32'h0000_0004);
    wr(CSF_OFF_MAIN_CONTROL, 32'h0000_0001);
    rd(CSF_OFF_MAIN_STATUS, 32'h0000_0C01);
    wr(CSF_OFF_MAIN_CONTROL, 32'h0000_0002);
    rd(CSF_OFF_MAIN_STATUS, 32'h0000_0C12);
    wr(CSF_OFF_MAIN_STATUS, 32'h0000_0010);
    rd(CSF_OFF_MAIN_STATUS, 32'h0000_0C02);
    wr(CSF_OFF_MAIN_CONTROL, 32'h0000_0000);
    wr(CSF_OFF_MAIN_CONTROL, 32'h0000_0002);
    wr(CSF_OFF_MAIN_CONTROL, 32'h0000_0000);
    rd(CSF_OFF_MAIN_STATUS, 32'h0000_0C00);
    // An error pulse while the clock enable is low must be ignored
    ce <= 1'b0;
    ev(7'h01);
    ce <= 1'b1;
    rd(CSF_OFF_MAIN_STATUS, 32'h0000_0C00);
    for (int i = 0; i < 8; i++) begin
      rs = xs(rs);
      txa <= rs[0];
      rxa <= rs[1];
      rxp <= rs[2];
      ev(7'h40);
      rxp <= ~rs[2];
      repeat (2) @(posedge clk);
      rd(CSF_OFF_MAIN_STATUS, {20'h0, ~rs[2], rs[2], rs[1], rs[0], 8'h00});
    end
    wr(CSF_OFF_EVENT_CONTROL, 32'h0000_0001);
    ev(7'h0C);
    rd(CSF_OFF_TRANSMIT_STATUS, 32'h1C00_0003);
    wr(CSF_OFF_EVENT_CONTROL, 32'h0000_0001);
    rd(CSF_OFF_TRANSMIT_STATUS, 32'h1C00_0002);
    ev(7'h34);
    rd(CSF_OFF_TRANSMIT_STATUS, 32'h1C00_000F);
    wr(CSF_OFF_TRANSMIT_STATUS, 32'hFFFF_FFF6);
    rd(CSF_OFF_TRANSMIT_STATUS, 32'h1C00_0009);
    wr(CSF_OFF_TRANSMIT_STATUS, 32'h0000_000F);
    rd(CSF_OFF_TRANSMIT_STATUS, CSF_RST_TRANSMIT_STATUS);
    rd(CSF_OFF_EVENT_CONTROL, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, CSF_UNMAPPED_DATA);
    // Two accepted transmit requests give two start pulses
    n_tests++;
    if (n_start != 2) begin
      failures++;
      $display("ERROR t=%0t starts=%h exp=%h", $time, n_start, 2);
    end
    test_done();
  end
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule : csf_status_flags_tb
`default_nettype wire
